// file: hdl/audio_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface audio_link_if;
  // bit clock, each end with its own drive and enable
  logic bclk_dev_o;
  logic bclk_dev_oe;
  logic bclk_host_o;
  logic bclk_host_oe;
  logic bclk;
  // frame clock
  logic lr_dev_o;
  logic lr_dev_oe;
  logic lr_host_o;
  logic lr_host_oe;
  logic lrclk;
  // one-way data lines
  logic sdata_to_dev;
  logic sdata_to_host;

  // wire level from enables; an undriven line reads low
  assign bclk = bclk_dev_oe ? bclk_dev_o : (bclk_host_oe ? bclk_host_o : 1'b0);
  assign lrclk = lr_dev_oe ? lr_dev_o : (lr_host_oe ? lr_host_o : 1'b0);

  modport device (
    output bclk_dev_o, bclk_dev_oe, lr_dev_o, lr_dev_oe, sdata_to_host,
    input bclk, lrclk, sdata_to_dev
  );
  modport host (
    output bclk_host_o, bclk_host_oe, lr_host_o, lr_host_oe, sdata_to_dev,
    input bclk, lrclk, sdata_to_host
  );
endinterface
`default_nettype wire

// file: hdl/audio_port_pkg.sv
package audio_port_pkg;
  // register map of each port
  localparam logic [7:0] DAC1_PORT_FORMAT_OFFSET = 8'h02;
  localparam logic [7:0] DAC1_CLOCK_RATIO_OFFSET = 8'h03;
  localparam logic [7:0] DAC1_MASTER_SELECT_OFFSET = 8'h04;
  localparam logic [7:0] DAC2_PORT_FORMAT_OFFSET = 8'h07;
  localparam logic [7:0] DAC2_CLOCK_RATIO_OFFSET = 8'h08;
  localparam logic [7:0] DAC2_MASTER_SELECT_OFFSET = 8'h09;
  localparam logic [7:0] ADC_PORT_FORMAT_OFFSET = 8'h0d;
  localparam logic [7:0] ADC_CLOCK_RATIO_OFFSET = 8'h0e;
  localparam logic [7:0] ADC_MASTER_SELECT_OFFSET = 8'h0f;
  localparam logic [15:0] PORT_FORMAT_RESET = 16'h000a;
  localparam logic [15:0] CLOCK_RATIO_RESET = 16'h0000;
  localparam logic [15:0] MASTER_SELECT_RESET = 16'h0000;
  // field positions
  localparam int FMT_LSB = 0;
  localparam int WL_LSB = 2;
  localparam int BCLK_INV_BIT = 4;
  localparam int FRAME_INV_BIT = 5;
  localparam int MASTER_BIT = 0;
  localparam int RATIO_LSB = 0;
  localparam int BCLK_RATE_LSB = 3;
  typedef enum logic [1:0] {
    FMT_RIGHT_JUSTIFIED = 2'h0,
    FMT_LEFT_JUSTIFIED = 2'h1,
    FMT_I2S = 2'h2,
    FMT_DSP = 2'h3
  } format_t;
  localparam logic [11:0] CNT_MAX = 12'hfff;
  localparam logic [11:0] DETECT_TOLERANCE = 12'h020;
  localparam logic [11:0] MIN_BCLK_DIV = 12'h002;

  // word length code to bits
  function automatic logic [5:0] word_len(input logic [1:0] code);
    case (code)
      2'h0: return 6'h10;
      2'h1: return 6'h14;
      2'h2: return 6'h18;
      default: return 6'h20;
    endcase
  endfunction

  // ratio code to master clocks per frame; auto falls back to 256fs
  function automatic logic [11:0] ratio_mclks(input logic [2:0] code);
    case (code)
      3'h1: return 12'h080;
      3'h2: return 12'h0c0;
      3'h3: return 12'h100;
      3'h4: return 12'h180;
      3'h5: return 12'h200;
      3'h6: return 12'h300;
      3'h7: return 12'h480;
      default: return 12'h100;
    endcase
  endfunction

  // master clocks per bit clock; reserved codes behave as divide by 4
  function automatic logic [11:0] bclk_div(input logic [2:0] rate, input logic [11:0] r);
    logic [11:0] d;
    case (rate)
      3'h1: d = 12'h008;
      3'h2: d = r >> 5;
      3'h3: d = r >> 6;
      3'h4: d = r >> 7;
      default: d = 12'h004;
    endcase
    return (d < MIN_BCLK_DIV) ? MIN_BCLK_DIV : d;
  endfunction

  // bit index of the first data bit after a frame boundary
  function automatic logic [11:0] first_bit(input logic [1:0] fmt, input logic dsp_b,
                                            input logic [11:0] half, input logic [5:0] wl);
    case (fmt)
      FMT_RIGHT_JUSTIFIED: return (half > {6'h0, wl}) ? half - {6'h0, wl} : 12'h000;
      FMT_LEFT_JUSTIFIED: return 12'h000;
      FMT_I2S: return 12'h001;
      default: return dsp_b ? 12'h000 : 12'h001;
    endcase
  endfunction

  // keep only the low wl bits of a shifted word
  function automatic logic [31:0] mask_word(input logic [31:0] w, input logic [5:0] wl);
    logic [32:0] m;
    m = (33'h1 << wl) - 33'h1;
    return w & m[31:0];
  endfunction
endpackage

// file: hdl/audio_source_sink.sv
`timescale 1ns/1ps
`default_nettype none
// far end: sends dac words, takes adc words, master or slave
module audio_source_sink #(
  parameter logic [11:0] BCLK_HALF_MCLKS = 12'h004,
  parameter logic [11:0] FRAME_HALF_BITS = 12'h020
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link setup, must match the codec port
  input wire logic drive_clocks,
  input wire logic [1:0] format,
  input wire logic [1:0] word_code,
  input wire logic dsp_mode_b,
  input wire logic bclk_invert,
  input wire logic frame_invert,
  // serial link
  audio_link_if.host link,
  // user side
  input wire logic [31:0] tx_left,
  input wire logic [31:0] tx_right,
  output logic [31:0] rx_left,
  output logic [31:0] rx_right,
  output logic rx_valid
);
  typedef struct packed {
    logic bclk_q;
    logic lr_at_s;
    logic lr_at_d;
    logic [11:0] scnt;
    logic [11:0] dcnt;
    logic [11:0] bcnt;
    logic [11:0] fcnt;
    logic [31:0] shreg;
    logic [31:0] rxl;
    logic [31:0] rxr;
    logic [31:0] txl;
    logic [31:0] txr;
    logic valid;
    logic dout;
    logic gen_bclk;
    logic gen_lr;
  } state_t;

  state_t s;
  state_t n;
  logic [5:0] wl;
  logic [11:0] wl12;
  logic [11:0] span;
  logic bclk_eff;
  logic lr_eff;

  assign wl = audio_port_pkg::word_len(word_code);
  assign wl12 = {6'h00, wl};
  assign span = (format == audio_port_pkg::FMT_DSP) ? {wl12[10:0], 1'b0} : wl12;
  assign bclk_eff = drive_clocks ? s.gen_bclk : (link.bclk ^ bclk_invert);
  assign lr_eff = drive_clocks ? s.gen_lr : (link.lrclk ^ frame_invert);
  assign link.bclk_host_o = s.gen_bclk ^ bclk_invert;
  assign link.bclk_host_oe = drive_clocks;
  assign link.lr_host_o = s.gen_lr ^ frame_invert;
  assign link.lr_host_oe = drive_clocks;
  assign link.sdata_to_dev = s.dout;
  assign rx_left = s.rxl;
  assign rx_right = s.rxr;
  assign rx_valid = s.valid;

  // next state
  always_comb begin
    logic bnd;
    logic [11:0] off;
    logic [11:0] pos;
    logic [11:0] idx;
    logic [31:0] word;
    logic [31:0] shifted;
    bnd = 1'b0;
    off = '0;
    pos = '0;
    idx = '0;
    word = '0;
    shifted = '0;
    n = s;
    n.valid = 1'b0;
    n.bclk_q = bclk_eff;

    // clock generator; a frame holds FRAME_HALF_BITS per half, at least one word
    if (!drive_clocks) begin
      n.bcnt = '0;
      n.fcnt = '0;
    end else begin
      n.bcnt = (s.bcnt >= {BCLK_HALF_MCLKS[10:0], 1'b0} - 12'h001) ? 12'h000 : s.bcnt + 12'h001;
      if (n.bcnt == 12'h000) begin
        n.fcnt = (s.fcnt >= {FRAME_HALF_BITS[10:0], 1'b0} - 12'h001) ? 12'h000 :
                 s.fcnt + 12'h001;
      end
    end
    n.gen_bclk = drive_clocks & (s.bcnt >= BCLK_HALF_MCLKS);
    case (format)
      audio_port_pkg::FMT_DSP: n.gen_lr = drive_clocks & (s.fcnt == 12'h000);
      audio_port_pkg::FMT_I2S: n.gen_lr = drive_clocks & (s.fcnt >= FRAME_HALF_BITS);
      default: n.gen_lr = drive_clocks & (s.fcnt < FRAME_HALF_BITS);
    endcase

    // take adc words on the rising edge
    if (bclk_eff && !s.bclk_q) begin
      n.lr_at_s = lr_eff;
      bnd = (format == audio_port_pkg::FMT_DSP) ? (lr_eff & ~s.lr_at_s) : (lr_eff ^ s.lr_at_s);
      n.scnt = bnd ? 12'h000 : ((s.scnt == audio_port_pkg::CNT_MAX) ? s.scnt : s.scnt + 12'h001);
      shifted = {s.shreg[30:0], link.sdata_to_host};
      n.shreg = shifted;
      if (format == audio_port_pkg::FMT_RIGHT_JUSTIFIED) begin
        if (bnd) begin
          if (s.lr_at_s) begin
            n.rxl = audio_port_pkg::mask_word(s.shreg, wl);
          end else begin
            n.rxr = audio_port_pkg::mask_word(s.shreg, wl);
            n.valid = 1'b1;
          end
        end
      end else begin
        off = audio_port_pkg::first_bit(format, dsp_mode_b, 12'h000, wl);
        // a full-length word after a one-bit offset ends on the boundary edge
        if (bnd && off == 12'h001 && s.scnt == span - 12'h001) begin
          if (format != audio_port_pkg::FMT_DSP && !s.lr_at_s) begin
            n.rxl = audio_port_pkg::mask_word(shifted, wl);
          end else begin
            n.rxr = audio_port_pkg::mask_word(shifted, wl);
            n.valid = 1'b1;
          end
        end
        pos = n.scnt - off;
        if (n.scnt >= off && pos < span) begin
          if (pos == wl12 - 12'h001) begin
            if (format == audio_port_pkg::FMT_DSP ||
                lr_eff == (format == audio_port_pkg::FMT_LEFT_JUSTIFIED)) begin
              n.rxl = audio_port_pkg::mask_word(shifted, wl);
            end else begin
              n.rxr = audio_port_pkg::mask_word(shifted, wl);
              n.valid = 1'b1;
            end
          end
          if (format == audio_port_pkg::FMT_DSP && pos == span - 12'h001) begin
            n.rxr = audio_port_pkg::mask_word(shifted, wl);
            n.valid = 1'b1;
          end
        end else begin
          n.shreg = s.shreg;
        end
      end
    end

    // drive dac words on the falling edge, zero outside the words
    if (!bclk_eff && s.bclk_q) begin
      n.lr_at_d = lr_eff;
      bnd = (format == audio_port_pkg::FMT_DSP) ? (lr_eff & ~s.lr_at_d) : (lr_eff ^ s.lr_at_d);
      if (bnd) begin
        n.dcnt = '0;
        n.txl = tx_left;
        n.txr = tx_right;
      end else begin
        n.dcnt = (s.dcnt == audio_port_pkg::CNT_MAX) ? s.dcnt : s.dcnt + 12'h001;
      end
      // rj: the far end knows its own half length
      off = audio_port_pkg::first_bit(format, dsp_mode_b, FRAME_HALF_BITS, wl);
      pos = n.dcnt - off;
      n.dout = 1'b0;
      if (n.dcnt >= off && pos < span) begin
        if (pos < wl12) begin
          idx = wl12 - 12'h001 - pos;
          word = (format == audio_port_pkg::FMT_DSP ||
                  lr_eff == (format != audio_port_pkg::FMT_I2S)) ? n.txl : n.txr;
        end else begin
          idx = span - 12'h001 - pos;
          word = n.txr;
        end
        n.dout = word[idx[4:0]];
      end
      // same wrap when sending: the old word's lsb sits in the boundary slot
      if (bnd && format != audio_port_pkg::FMT_RIGHT_JUSTIFIED && off == 12'h001 &&
          s.dcnt == span - 12'h001) begin
        n.dout = (format != audio_port_pkg::FMT_DSP && !s.lr_at_d) ? s.txl[0] : s.txr[0];
      end
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule // audio_source_sink
`default_nettype wire

// file: hdl/codec_audio_port.sv
`timescale 1ns/1ps
`default_nettype none
// one port of the codec; instantiate twice as dac and once as adc
module codec_audio_port #(
  parameter bit IS_ADC = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register contents
  input wire logic [15:0] port_format,
  input wire logic [15:0] clock_ratio,
  input wire logic [15:0] master_select,
  input wire logic dsp_mode_b,
  // serial link
  audio_link_if.device link,
  // user side
  input wire logic [31:0] adc_left,
  input wire logic [31:0] adc_right,
  output logic [31:0] dac_left,
  output logic [31:0] dac_right,
  output logic dac_valid,
  output logic [2:0] detected_ratio
);
  typedef struct packed {
    logic bclk_q;
    logic lr_q;
    logic lr_at_s;
    logic lr_at_d;
    logic [11:0] scnt;
    logic [11:0] dcnt;
    logic [11:0] half_len;
    logic [11:0] mcnt;
    logic [11:0] bcnt;
    logic [11:0] meas;
    logic [31:0] shreg;
    logic [31:0] rx_left;
    logic [31:0] rx_right;
    logic [31:0] tx_left;
    logic [31:0] tx_right;
    logic rx_valid;
    logic dout;
    logic gen_bclk;
    logic gen_lr;
    logic [2:0] det;
  } state_t;

  state_t s;
  state_t n;
  logic [1:0] fmt;
  logic [5:0] wl;
  logic [11:0] wl12;
  logic [11:0] span;
  logic bcp;
  logic lrp;
  logic mstr;
  logic [2:0] sr;
  logic [11:0] ratio_m;
  logic [11:0] bdiv;
  logic bclk_eff;
  logic lr_eff;

  // field decode
  assign fmt = port_format[audio_port_pkg::FMT_LSB +: 2];
  assign wl = audio_port_pkg::word_len(port_format[audio_port_pkg::WL_LSB +: 2]);
  assign wl12 = {6'h00, wl};
  assign span = (fmt == audio_port_pkg::FMT_DSP) ? {wl12[10:0], 1'b0} : wl12;
  assign bcp = port_format[audio_port_pkg::BCLK_INV_BIT];
  assign lrp = port_format[audio_port_pkg::FRAME_INV_BIT];
  assign mstr = master_select[audio_port_pkg::MASTER_BIT];
  assign sr = clock_ratio[audio_port_pkg::RATIO_LSB +: 3];
  assign ratio_m = audio_port_pkg::ratio_mclks(sr);
  assign bdiv = audio_port_pkg::bclk_div(clock_ratio[audio_port_pkg::BCLK_RATE_LSB +: 3],
                                         ratio_m);
  // in master mode the generated clocks are already in the internal sense
  assign bclk_eff = mstr ? s.gen_bclk : (link.bclk ^ bcp);
  assign lr_eff = mstr ? s.gen_lr : (link.lrclk ^ lrp);

  // pins; the polarity bits are applied on the way out too
  assign link.bclk_dev_o = s.gen_bclk ^ bcp;
  assign link.bclk_dev_oe = mstr;
  assign link.lr_dev_o = s.gen_lr ^ lrp;
  assign link.lr_dev_oe = mstr;
  assign link.sdata_to_host = s.dout;
  assign dac_left = s.rx_left;
  assign dac_right = s.rx_right;
  assign dac_valid = s.rx_valid;
  assign detected_ratio = s.det;

  // nearest supported ratio within the tolerance, else auto
  function automatic logic [2:0] detect(input logic [11:0] m);
    logic [2:0] d;
    logic [11:0] r;
    d = 3'h0;
    for (int k = 1; k < 8; k++) begin
      r = audio_port_pkg::ratio_mclks(k[2:0]);
      if (!(IS_ADC && (k < 3 || k == 7)) &&
          ((m >= r) ? (m - r) : (r - m)) <= audio_port_pkg::DETECT_TOLERANCE) begin
        d = k[2:0];
      end
    end
    return d;
  endfunction

  // next state
  always_comb begin
    logic s_edge;
    logic d_edge;
    logic bnd;
    logic bitv;
    logic [11:0] off;
    logic [11:0] pos;
    logic [11:0] idx;
    logic [31:0] word;
    logic [31:0] shifted;
    s_edge = 1'b0;
    d_edge = 1'b0;
    bnd = 1'b0;
    bitv = 1'b0;
    off = '0;
    pos = '0;
    idx = '0;
    word = '0;
    shifted = '0;
    n = s;
    n.rx_valid = 1'b0;
    n.bclk_q = bclk_eff;
    n.lr_q = lr_eff;
    s_edge = bclk_eff & ~s.bclk_q;
    d_edge = ~bclk_eff & s.bclk_q;

    // master generator, held at a frame start while slave
    if (!mstr) begin
      n.mcnt = '0;
      n.bcnt = '0;
    end else begin
      n.mcnt = (s.mcnt >= ratio_m - 12'h001) ? 12'h000 : s.mcnt + 12'h001;
      n.bcnt = (s.mcnt >= ratio_m - 12'h001 || s.bcnt >= bdiv - 12'h001) ? 12'h000 :
               s.bcnt + 12'h001;
    end
    // falling bit clock and frame change share the frame start
    n.gen_bclk = mstr & (s.bcnt >= (bdiv >> 1));
    case (fmt)
      audio_port_pkg::FMT_DSP: n.gen_lr = mstr & (s.mcnt < bdiv);
      audio_port_pkg::FMT_I2S: n.gen_lr = mstr & (s.mcnt >= (ratio_m >> 1));
      default: n.gen_lr = mstr & (s.mcnt < (ratio_m >> 1));
    endcase

    // slave ratio measurement between frame rises
    n.meas = (s.meas == audio_port_pkg::CNT_MAX) ? s.meas : s.meas + 12'h001;
    if (!mstr && lr_eff && !s.lr_q) begin
      n.det = detect(s.meas + 12'h001);
      n.meas = '0;
    end

    // receive on the sampling edge
    if (s_edge) begin
      n.lr_at_s = lr_eff;
      bnd = (fmt == audio_port_pkg::FMT_DSP) ? (lr_eff & ~s.lr_at_s) : (lr_eff ^ s.lr_at_s);
      n.scnt = bnd ? 12'h000 : ((s.scnt == audio_port_pkg::CNT_MAX) ? s.scnt : s.scnt + 12'h001);
      shifted = {s.shreg[30:0], link.sdata_to_dev};
      n.shreg = shifted;
      if (fmt == audio_port_pkg::FMT_RIGHT_JUSTIFIED) begin
        // lsb came on the edge before this change
        if (bnd) begin
          if (s.lr_at_s) begin
            n.rx_left = audio_port_pkg::mask_word(s.shreg, wl);
          end else begin
            n.rx_right = audio_port_pkg::mask_word(s.shreg, wl);
            n.rx_valid = ~IS_ADC;
          end
        end
      end else begin
        off = audio_port_pkg::first_bit(fmt, dsp_mode_b, 12'h000, wl);
        // a full-length word after a one-bit offset ends on the boundary edge
        if (bnd && off == 12'h001 && s.scnt == span - 12'h001) begin
          if (fmt != audio_port_pkg::FMT_DSP && !s.lr_at_s) begin
            n.rx_left = audio_port_pkg::mask_word(shifted, wl);
          end else begin
            n.rx_right = audio_port_pkg::mask_word(shifted, wl);
            n.rx_valid = ~IS_ADC;
          end
        end
        pos = n.scnt - off;
        if (n.scnt >= off && pos < span) begin
          if (pos == wl12 - 12'h001) begin
            if (fmt == audio_port_pkg::FMT_DSP ||
                lr_eff == (fmt == audio_port_pkg::FMT_LEFT_JUSTIFIED)) begin
              n.rx_left = audio_port_pkg::mask_word(shifted, wl);
            end else begin
              n.rx_right = audio_port_pkg::mask_word(shifted, wl);
              n.rx_valid = ~IS_ADC;
            end
          end
          if (fmt == audio_port_pkg::FMT_DSP && pos == span - 12'h001) begin
            n.rx_right = audio_port_pkg::mask_word(shifted, wl);
            n.rx_valid = ~IS_ADC;
          end
        end else begin
          n.shreg = s.shreg;
        end
      end
    end

    // transmit on the driving edge
    if (d_edge) begin
      n.lr_at_d = lr_eff;
      bnd = (fmt == audio_port_pkg::FMT_DSP) ? (lr_eff & ~s.lr_at_d) : (lr_eff ^ s.lr_at_d);
      if (bnd) begin
        n.dcnt = '0;
        n.half_len = s.dcnt + 12'h001; // rj assumes this half as long as the last
        n.tx_left = adc_left;
        n.tx_right = adc_right;
      end else begin
        n.dcnt = (s.dcnt == audio_port_pkg::CNT_MAX) ? s.dcnt : s.dcnt + 12'h001;
      end
      off = audio_port_pkg::first_bit(fmt, dsp_mode_b, n.half_len, wl);
      pos = n.dcnt - off;
      if (n.dcnt >= off && pos < span) begin
        if (pos < wl12) begin
          idx = wl12 - 12'h001 - pos;
          word = (fmt == audio_port_pkg::FMT_DSP ||
                  lr_eff == (fmt != audio_port_pkg::FMT_I2S)) ? n.tx_left : n.tx_right;
        end else begin
          idx = span - 12'h001 - pos;
          word = n.tx_right;
        end
        bitv = word[idx[4:0]];
      end
      // same wrap when sending: the old word's lsb sits in the boundary slot
      if (bnd && fmt != audio_port_pkg::FMT_RIGHT_JUSTIFIED && off == 12'h001 &&
          s.dcnt == span - 12'h001) begin
        bitv = (fmt != audio_port_pkg::FMT_DSP && !s.lr_at_d) ? s.tx_left[0] : s.tx_right[0];
      end
      n.dout = IS_ADC & bitv;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule // codec_audio_port
`default_nettype wire

// file: verif/audio_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// watches the adc link, where the codec end drives the data line
module audio_link_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link signals
  input wire logic bclk_dev_o,
  input wire logic bclk_dev_oe,
  input wire logic lr_dev_o,
  input wire logic lr_dev_oe,
  input wire logic bclk,
  input wire logic lrclk,
  input wire logic sdata_to_host,
  // codec port setup and words
  input wire logic [15:0] port_format,
  input wire logic [15:0] clock_ratio,
  input wire logic [15:0] master_select,
  input wire logic dsp_mode_b,
  input wire logic [31:0] adc_left,
  input wire logic [31:0] adc_right
);
  logic beff, leff, b_q, l_q, rise, bnd, lr_seen;
  logic [6:0] idx;
  logic [2:0] nb;
  logic [9:0] lr_cnt;
  logic [5:0] wl;
  logic [1:0] fmt;
  logic [31:0] cur;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // internal sense of the pins, polarity taken back out
  assign beff = bclk ^ port_format[4];
  assign leff = lrclk ^ port_format[5];
  assign fmt = port_format[1:0];
  assign wl = (port_format[3:2] == 2'h3) ? 6'h20 : 6'h10 + {2'h0, port_format[3:2], 2'h0};
  assign rise = beff & ~b_q;
  assign bnd = (fmt == 2'h3) ? (leff & ~l_q) : (leff ^ l_q);
  assign cur = leff ? adc_left : adc_right;
  // rises since the frame edge; nb starts at 4 so the first three frame edges,
  // whose halves may be short, are skipped even in dsp where edges are rare
  always_ff @(posedge mclk) begin
    if (rst) begin
      b_q <= 1'b0;
      l_q <= 1'b0;
      idx <= 7'h00;
      nb <= 3'h4;
      lr_cnt <= 10'h000;
      lr_seen <= 1'b0;
    end else begin
      b_q <= beff;
      l_q <= leff;
      if (bnd) begin
        idx <= 7'h00;
        nb <= (nb == 3'h7) ? nb : nb + 3'h1;
      end else if (rise) begin
        idx <= idx + 7'h01;
      end
      lr_cnt <= $rose(lr_dev_o) ? 10'h000 : lr_cnt + 10'h001;
      lr_seen <= lr_seen | $rose(lr_dev_o);
    end
  end

  clock_enable_a: assert property (
    bclk_dev_oe == master_select[0] && lr_dev_oe == master_select[0])
    else $error("clock enables differ from master select");
  bclk_period_a: assert property (
    master_select[0] && clock_ratio[5:3] inside {3'h1, 3'h3} && $rose(bclk_dev_o)
    |=> (!$rose(bclk_dev_o)) [*7] ##1 $rose(bclk_dev_o)) else $error("bit clock period wrong");
  frame_period_a: assert property (
    master_select[0] && clock_ratio[2:0] == 3'h5 && lr_seen && $rose(lr_dev_o)
    |-> lr_cnt == 10'h1ff) else $error("frame clock period wrong");
  data_change_a: assert property (
    $changed(sdata_to_host) |-> !beff) else $error("data changed while bit clock high");
  lj_msb_a: assert property (
    nb == 3'h7 && fmt == 2'h1 && rise && idx == 7'h00 |-> sdata_to_host == cur[wl - 6'h01])
    else $error("left justified msb wrong");
  i2s_msb_a: assert property (
    nb == 3'h7 && fmt == 2'h2 && rise && idx == 7'h01
    |-> sdata_to_host == (leff ? adc_right[wl - 6'h01] : adc_left[wl - 6'h01]))
    else $error("i2s msb wrong");
  dsp_left_a: assert property (
    nb == 3'h7 && fmt == 2'h3 && rise && idx == {6'h00, ~dsp_mode_b}
    |-> sdata_to_host == adc_left[wl - 6'h01]) else $error("dsp left msb wrong");
  dsp_right_a: assert property (
    nb == 3'h7 && fmt == 2'h3 && rise && idx == {1'b0, wl} + {6'h00, ~dsp_mode_b}
    |-> sdata_to_host == adc_right[wl - 6'h01]) else $error("dsp right msb wrong");
  rj_lsb_a: assert property (
    nb == 3'h7 && fmt == 2'h0 && rise && idx == 7'h1f |-> sdata_to_host == cur[0])
    else $error("right justified lsb wrong");
  surplus_zero_a: assert property (
    nb == 3'h7 && rise && ((fmt == 2'h1 && idx >= {1'b0, wl}) || (fmt == 2'h2 && idx > {1'b0, wl}))
    |-> !sdata_to_host) else $error("surplus bit not zero");
endmodule // audio_link_monitor
`default_nettype wire

// file: verif/codec_audio_serial_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
module codec_audio_serial_ports_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] fmt = 2'h2;
  logic [1:0] wcode = 2'h2;
  logic dspb = 1'b0, binv = 1'b0, finv = 1'b0, cmaster = 1'b0;
  logic [2:0] ratio = 3'h0, rate = 3'h0;
  logic [31:0] tx_l = 32'h0, tx_r = 32'h0, ad_l = 32'h0, ad_r = 32'h0;
  logic [15:0] port_format, clock_ratio, master_select;
  logic [31:0] dac_left, dac_right, rx_left, rx_right;
  logic dac_valid, rx_valid;
  logic [2:0] det_dac, det_adc;
  int miscompares = 0;
  int n_checks = 0;
  int seq = 0;
  audio_link_if dac_link ();
  audio_link_if adc_link ();
  // register contents built from the test setup
  assign port_format = {10'h000, finv, binv, wcode, fmt};
  assign clock_ratio = {10'h000, rate, ratio};
  assign master_select = {15'h0000, cmaster};
  always #5 mclk = ~mclk;

  codec_audio_port #(.IS_ADC(1'b0)) u_codec_audio_port (.mclk(mclk), .rst(rst),
    .port_format(port_format), .clock_ratio(clock_ratio), .master_select(master_select),
    .dsp_mode_b(dspb), .link(dac_link), .adc_left(ad_l), .adc_right(ad_r),
    .dac_left(dac_left), .dac_right(dac_right), .dac_valid(dac_valid), .detected_ratio(det_dac));
  codec_audio_port #(.IS_ADC(1'b1)) u_codec_audio_port_adc (.mclk(mclk), .rst(rst),
    .port_format(port_format), .clock_ratio(clock_ratio), .master_select(master_select),
    .dsp_mode_b(dspb), .link(adc_link), .adc_left(ad_l), .adc_right(ad_r),
    .dac_left(), .dac_right(), .dac_valid(), .detected_ratio(det_adc));
  audio_source_sink u_audio_source_sink (.mclk(mclk), .rst(rst), .drive_clocks(!cmaster),
    .format(fmt), .word_code(wcode), .dsp_mode_b(dspb), .bclk_invert(binv),
    .frame_invert(finv), .link(dac_link), .tx_left(tx_l), .tx_right(tx_r),
    .rx_left(), .rx_right(), .rx_valid());
  audio_source_sink u_audio_source_sink_adc (.mclk(mclk), .rst(rst), .drive_clocks(!cmaster),
    .format(fmt), .word_code(wcode), .dsp_mode_b(dspb), .bclk_invert(binv),
    .frame_invert(finv), .link(adc_link), .tx_left(tx_l), .tx_right(tx_r),
    .rx_left(rx_left), .rx_right(rx_right), .rx_valid(rx_valid));
  audio_link_monitor u_audio_link_monitor (.mclk(mclk), .rst(rst),
    .bclk_dev_o(adc_link.bclk_dev_o), .bclk_dev_oe(adc_link.bclk_dev_oe),
    .lr_dev_o(adc_link.lr_dev_o), .lr_dev_oe(adc_link.lr_dev_oe), .bclk(adc_link.bclk),
    .lrclk(adc_link.lrclk), .sdata_to_host(adc_link.sdata_to_host),
    .port_format(port_format), .clock_ratio(clock_ratio), .master_select(master_select),
    .dsp_mode_b(dspb), .adc_left(ad_l), .adc_right(ad_r));

  // expected word: only the low word-length bits survive
  function automatic logic [31:0] keep(input logic [31:0] w, input logic [1:0] c);
    return (c == 2'h3) ? w : w & ((32'h1 << (16 + 4 * c)) - 32'h1);
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_code(input logic [2:0] got, input logic [2:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // setup is changed only under reset, since a running port must keep its format
  task automatic run(input logic [1:0] f, input logic b, input logic m, input logic rnd);
    int nd;
    int na;
    @(negedge mclk);
    rst = 1'b1;
    fmt = f;
    dspb = b;
    cmaster = m;
    // corner: dsp a with 32-bit words fills the frame and wraps its last bit
    wcode = !rnd ? 2'h2 : (f == 2'h0) ? 2'($urandom % 3) : (f == 2'h3 && !b) ? 2'h3 :
            2'($urandom % 4);
    binv = rnd & 1'($urandom);
    finv = rnd & 1'($urandom);
    ratio = (m || (rnd && $urandom % 2)) ? 3'h5 : 3'h0;
    rate = ($urandom % 2) ? 3'h1 : 3'h3;
    tx_l = $urandom;
    tx_r = $urandom;
    ad_l = $urandom;
    ad_r = $urandom;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    nd = 0;
    na = 0;
    // six stereo pairs each way: early frames may be partial
    for (int i = 0; i < 5000 && (nd < 6 || na < 6); i++) begin
      @(negedge mclk);
      nd += int'(dac_valid === 1'b1);
      na += int'(rx_valid === 1'b1);
    end
    if (nd < 6 || na < 6) begin
      miscompares++;
      $display("mismatch at %0t: words stopped arriving", $time);
    end
    chk_word(dac_left, keep(tx_l, wcode), "dac left");
    chk_word(dac_right, keep(tx_r, wcode), "dac right");
    chk_word(rx_left, keep(ad_l, wcode), "adc left");
    chk_word(rx_right, keep(ad_r, wcode), "adc right");
    if (!m && ratio == 3'h0) begin
      chk_code(det_dac, 3'h5, "dac ratio");
      chk_code(det_adc, 3'h5, "adc ratio");
    end
    seq++;
    $display("test %0d done format %0d words %0d master %0d", seq, f, wcode, m);
  endtask

  // watchdog sized for sixteen tests of about 5100 cycles each
  initial begin
    repeat (16 * 5100) @(posedge mclk);
    miscompares++;
    $display("mismatch at %0t: run did not finish", $time);
    wrap_up;
  end

  // reset values first except a random bit clock rate, then every format in slave and in master, then extras
  initial begin
    void'($urandom(32'h034f));
    run(2'h2, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 15; k++) begin
      run((k % 5 == 4) ? 2'h3 : 2'(k % 5), k % 5 == 4 && k != 14, 1'((k / 5) % 2),
          1'b1);
    end
    wrap_up;
  end
endmodule // codec_audio_serial_ports_tb
`default_nettype wire
